// ===== dsos_params.svh
`ifndef DSOS_PARAMS_SVH
`define DSOS_PARAMS_SVH

// ----------------------------------------------------------------
// function codes
// ----------------------------------------------------------------
`define DSOS_FC_RUNNING        8'h00
`define DSOS_FC_ZERO_SPEED     8'h01
`define DSOS_FC_AGREE_CMD      8'h02
`define DSOS_FC_AGREE_SET      8'h03
`define DSOS_FC_DETECT_LOW     8'h04
`define DSOS_FC_DETECT_HIGH    8'h05
`define DSOS_FC_READY          8'h06
`define DSOS_FC_UNDERVOLT      8'h07
`define DSOS_FC_BASE_BLOCK     8'h08
`define DSOS_FC_OPER_SPEED     8'h09
`define DSOS_FC_OPER_RUN       8'h0A
`define DSOS_FC_TORQUE         8'h0B
`define DSOS_FC_REF_LOSS       8'h0C
`define DSOS_FC_BRAKE_HOT      8'h0D
`define DSOS_FC_MAJOR_FAULT    8'h0E
`define DSOS_FC_MINOR_FAULT    8'h10
`define DSOS_FC_RESET_CMD      8'h11
`define DSOS_FC_TIMER          8'h12
`define DSOS_FC_REVERSE_OPEN   8'h17
`define DSOS_FC_RESTART        8'h18
`define DSOS_FC_HEAT_PREALARM  8'h20
`define DSOS_FC_ENABLE         8'h38
`define DSOS_FC_RUN_WAIT       8'h39
`define DSOS_FC_FAN_FAIL       8'h3D

// ----------------------------------------------------------------
// reset selections
// ----------------------------------------------------------------
`define DSOS_FIRST_SEL_RST     8'h00
`define DSOS_SECOND_SEL_RST    8'h0A

// ----------------------------------------------------------------
// reference loss timing
// ----------------------------------------------------------------
`define DSOS_LOSS_WINDOW_MS    400
`define DSOS_CLK_KHZ           100000
`define DSOS_LOSS_WINDOW_CYC   (`DSOS_LOSS_WINDOW_MS * `DSOS_CLK_KHZ)
`define DSOS_LOSS_DROP_PCT     90
`define DSOS_PCT_FULL          100

`endif

// ===== dsos_pkg.sv
package dsos_pkg;
    typedef logic [7:0] dsos_code_t;
endpackage

// ===== dsos_top.sv
`timescale 1ns/1ps
`include "dsos_params.svh"

module dsos_top #(
    parameter int SW                = 16,
    parameter int LOSS_WINDOW_CYC   = `DSOS_LOSS_WINDOW_CYC
) (
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire dsos_pkg::dsos_code_t first_output_function_select,
    input  wire dsos_pkg::dsos_code_t second_output_function_select,
    input  wire logic                run_command,
    input  wire logic                voltage_output,
    input  wire logic [SW-1:0]       output_speed,
    input  wire logic [SW-1:0]       speed_command,
    input  wire logic [SW-1:0]       analog_reference,
    input  wire logic [SW-1:0]       minimum_frequency_setting,
    input  wire logic [SW-1:0]       speed_detection_level,
    input  wire logic [SW-1:0]       speed_agreement_bandwidth,
    input  wire logic                fault_present,
    input  wire logic                programming_mode,
    input  wire logic                bus_undervoltage,
    input  wire logic                speed_source_keypad,
    input  wire logic                run_source_keypad,
    input  wire logic                torque_over_level,
    input  wire logic                reference_loss_enable,
    input  wire logic                brake_overheat,
    input  wire logic                major_fault,
    input  wire logic                minor_fault,
    input  wire logic                reset_command,
    input  wire logic                timer_output,
    input  wire logic                reverse_run,
    input  wire logic                restart_active,
    input  wire logic                heatsink_prealarm,
    input  wire logic                drive_enable,
    input  wire logic                run_delay_wait,
    input  wire logic                fan_failure,
    output logic                     first_contact_output,
    output logic                     second_contact_output,
    output logic                     reference_lost
);
    import dsos_pkg::*;

    // ----------------------------------------------------------------
    // speed comparisons
    // ----------------------------------------------------------------
    function automatic logic within_band(input logic [SW-1:0] a, input logic [SW-1:0] b,
                                         input logic [SW-1:0] bw);
        logic [SW-1:0] d;
        d = (a > b) ? a - b : b - a;
        return d <= bw;
    endfunction

    wire logic [SW:0] level_up   = {1'b0, speed_detection_level} + {1'b0, speed_agreement_bandwidth};
    wire logic [SW:0] level_dn   = (speed_detection_level > speed_agreement_bandwidth)
                                 ? {1'b0, speed_detection_level - speed_agreement_bandwidth} : '0;
    wire logic        zero_speed = output_speed < minimum_frequency_setting;
    wire logic        agree_cmd  = within_band(output_speed, speed_command, speed_agreement_bandwidth);
    wire logic        agree_set  = within_band(output_speed, speed_detection_level, speed_agreement_bandwidth)
                                 && within_band(speed_command, speed_detection_level,
                                                speed_agreement_bandwidth);

    logic det_low_r;
    logic det_high_r;
    wire logic det_low_nxt  = ({1'b0, output_speed} <= {1'b0, speed_detection_level}) ? 1'b1
                            : ({1'b0, output_speed} > level_up) ? 1'b0 : det_low_r;
    wire logic det_high_nxt = ({1'b0, output_speed} >= {1'b0, speed_detection_level}) ? 1'b1
                            : ({1'b0, output_speed} < level_dn) ? 1'b0 : det_high_r;

    // ----------------------------------------------------------------
    // reference loss: drop of 90% against value held at window start
    // ----------------------------------------------------------------
    logic [31:0]   win_cnt_r;
    logic [SW-1:0] ref_base_r;
    logic          loss_r;
    wire  logic    win_end    = (win_cnt_r >= 32'(LOSS_WINDOW_CYC - 1));
    wire  logic [SW+7:0] ref_x100  = (SW+8)'(analog_reference) * (SW+8)'(`DSOS_PCT_FULL);
    wire  logic [SW+7:0] base_x10  = (SW+8)'(ref_base_r)
                                   * (SW+8)'(`DSOS_PCT_FULL - `DSOS_LOSS_DROP_PCT);
    wire  logic    drop_seen  = (ref_base_r != '0) && (ref_x100 <= base_x10);
    wire  logic    loss_nxt   = reference_loss_enable && (drop_seen || (loss_r && analog_reference <= ref_base_r));

    // ----------------------------------------------------------------
    // status conditions gathered into one vector
    // ----------------------------------------------------------------
    // the selector reads this vector as an argument, so a change of any
    // status input re-evaluates both contacts, not only a code change
    localparam int NCOND = 24;

    wire logic [NCOND-1:0] cond;

    assign cond[0]  = run_command || voltage_output;
    assign cond[1]  = zero_speed;
    assign cond[2]  = agree_cmd;
    assign cond[3]  = agree_set;
    assign cond[4]  = det_low_nxt;
    assign cond[5]  = det_high_nxt;
    assign cond[6]  = !fault_present && !programming_mode;
    assign cond[7]  = bus_undervoltage;
    assign cond[8]  = !voltage_output;
    assign cond[9]  = speed_source_keypad;
    assign cond[10] = run_source_keypad;
    assign cond[11] = torque_over_level;
    assign cond[12] = loss_nxt;
    assign cond[13] = brake_overheat;
    assign cond[14] = major_fault;
    assign cond[15] = minor_fault;
    assign cond[16] = reset_command;
    assign cond[17] = timer_output;
    assign cond[18] = !reverse_run;
    assign cond[19] = restart_active;
    assign cond[20] = heatsink_prealarm;
    assign cond[21] = drive_enable;
    assign cond[22] = run_delay_wait;
    assign cond[23] = fan_failure;

    // ----------------------------------------------------------------
    // function code selection
    // ----------------------------------------------------------------
    function automatic logic pick(input dsos_code_t code, input logic [NCOND-1:0] c);
        unique case (code)
            `DSOS_FC_RUNNING:       return c[0];
            `DSOS_FC_ZERO_SPEED:    return c[1];
            `DSOS_FC_AGREE_CMD:     return c[2];
            `DSOS_FC_AGREE_SET:     return c[3];
            `DSOS_FC_DETECT_LOW:    return c[4];
            `DSOS_FC_DETECT_HIGH:   return c[5];
            `DSOS_FC_READY:         return c[6];
            `DSOS_FC_UNDERVOLT:     return c[7];
            `DSOS_FC_BASE_BLOCK:    return c[8];
            `DSOS_FC_OPER_SPEED:    return c[9];
            `DSOS_FC_OPER_RUN:      return c[10];
            `DSOS_FC_TORQUE:        return c[11];
            `DSOS_FC_REF_LOSS:      return c[12];
            `DSOS_FC_BRAKE_HOT:     return c[13];
            `DSOS_FC_MAJOR_FAULT:   return c[14];
            `DSOS_FC_MINOR_FAULT:   return c[15];
            `DSOS_FC_RESET_CMD:     return c[16];
            `DSOS_FC_TIMER:         return c[17];
            `DSOS_FC_REVERSE_OPEN:  return c[18];
            `DSOS_FC_RESTART:       return c[19];
            `DSOS_FC_HEAT_PREALARM: return c[20];
            `DSOS_FC_ENABLE:        return c[21];
            `DSOS_FC_RUN_WAIT:      return c[22];
            `DSOS_FC_FAN_FAIL:      return c[23];
            default:                return 1'b0;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // per contact selection
    // ----------------------------------------------------------------
    wire dsos_code_t contact_sel [2];
    wire logic       contact_nxt [2];

    assign contact_sel[0] = first_output_function_select;
    assign contact_sel[1] = second_output_function_select;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_contact
            assign contact_nxt[gi] = pick(contact_sel[gi], cond);
        end
    endgenerate

    // ----------------------------------------------------------------
    // speed detection hysteresis state
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            det_low_r <= 1'b1;
        end
        else
        begin
            det_low_r <= det_low_nxt;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            det_high_r <= 1'b0;
        end
        else
        begin
            det_high_r <= det_high_nxt;
        end
    end

    // ----------------------------------------------------------------
    // reference loss window and base sample
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            win_cnt_r <= '0;
        end
        else
        begin
            win_cnt_r <= win_end ? '0 : win_cnt_r + 32'd1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ref_base_r <= '0;
        end
        else
        begin
            ref_base_r <= win_end ? analog_reference : ref_base_r;
        end
    end

    // ----------------------------------------------------------------
    // reference loss flag
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            loss_r <= 1'b0;
        end
        else
        begin
            loss_r <= loss_nxt;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            reference_lost <= 1'b0;
        end
        else
        begin
            reference_lost <= loss_nxt;
        end
    end

    // ----------------------------------------------------------------
    // contact outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            first_contact_output <= 1'b0;
        end
        else
        begin
            first_contact_output <= contact_nxt[0];
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            second_contact_output <= 1'b0;
        end
        else
        begin
            second_contact_output <= contact_nxt[1];
        end
    end
endmodule

// ===== dsos_checker_assertions.sv
`timescale 1ns/1ps
// ----------------------------------------
// contact selection checks
// ----------------------------------------
module dsos_checker #(
    parameter int LOSS_WINDOW_CYC = 20
) (
    input wire logic                 clk,
    input wire logic                 rst_n,
    input wire dsos_pkg::dsos_code_t first_output_function_select,
    input wire dsos_pkg::dsos_code_t second_output_function_select,
    input wire logic                 run_command,
    input wire logic                 voltage_output,
    input wire logic                 fault_present,
    input wire logic                 programming_mode,
    input wire logic                 reverse_run,
    input wire logic                 first_contact_output,
    input wire logic                 second_contact_output
);
    import dsos_pkg::*;
    wire dsos_code_t s1 = first_output_function_select;
    wire dsos_code_t s2 = second_output_function_select;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    chk_run_close: assert property (s1 == 8'h00 && (run_command || voltage_output) |=> first_contact_output)
        else $error("run code not closed");
    chk_run_open: assert property (s1 == 8'h00 && !run_command && !voltage_output |=> !first_contact_output)
        else $error("run code not open");
    chk_ready_open: assert property (s2 == 8'h06 && (fault_present || programming_mode) |=> !second_contact_output)
        else $error("ready code closed on fault");
    chk_base_block: assert property (s1 == 8'h08 |=> first_contact_output != $past(voltage_output))
        else $error("base block code wrong");
    chk_reverse_open: assert property (s2 == 8'h17 |=> second_contact_output != $past(reverse_run))
        else $error("reverse code wrong");
    chk_unknown_open: assert property (s1 == 8'h0F || s1 == 8'h13 || s1 == 8'hFF |=> !first_contact_output)
        else $error("unknown code closed");
    chk_own_select: assert property (s2 == 8'h0F |-> ##1 !second_contact_output [*1])
        else $error("second contact ignores its code");
    chk_reset_open: assert property (disable iff (1'b0) !rst_n |=> !first_contact_output && !second_contact_output)
        else $error("contact closed in reset");
    cover property (s1 == 8'h00 && run_command ##1 first_contact_output);
    cover property (s2 == 8'h17 && reverse_run ##1 !second_contact_output);
    cover property (s2 == 8'h06 && fault_present ##1 !second_contact_output);
endmodule
bind dsos_top dsos_checker #(.LOSS_WINDOW_CYC(LOSS_WINDOW_CYC)) u_dsos_checker (.*);

// ===== dsos_relay_load.sv
`timescale 1ns/1ps
// ----------------------------------------
// relay coil load: counts contact closures
// ----------------------------------------
module dsos_relay_load (
    input  wire logic   clk,
    input  wire logic   rst_n,
    input  wire logic   contact,
    output logic [15:0] closures_r
);
    logic last_r;
    always_ff @(posedge clk)
    begin
        last_r     <= contact;
        closures_r <= !rst_n ? 16'h0000 : closures_r + {15'h0000, contact & !last_r};
    end
endmodule

// ===== drive_status_output_selector_tb.sv
`timescale 1ns/1ps
// ----------------------------------------
// contact selector bench
// ----------------------------------------
module drive_status_output_selector_tb;
    import dsos_pkg::*;
    logic clk = 0, rst_n = 0, loss_en = 0, c1, c2, lost;
    logic [18:0] st = '0;
    dsos_code_t s1 = 8'h00, s2 = 8'h00;
    logic [15:0] spd = '0, cmd = '0, ref_v = '0, clo;
    int error_cnt = 0, cmp_count = 0;
    dsos_code_t codes [14] = '{8'h07, 8'h09, 8'h0A, 8'h0B, 8'h0D, 8'h0E, 8'h10, 8'h11, 8'h12, 8'h18, 8'h20, 8'h38, 8'h39, 8'h3D};
    int bits [14] = '{4, 5, 6, 7, 8, 9, 10, 11, 12, 14, 15, 16, 17, 18};
    dsos_top #(.SW(16), .LOSS_WINDOW_CYC(20)) u_dsos_top (.clk(clk), .rst_n(rst_n),
        .first_output_function_select(s1), .second_output_function_select(s2), .run_command(st[0]),
        .voltage_output(st[1]), .fault_present(st[2]), .programming_mode(st[3]), .bus_undervoltage(st[4]),
        .speed_source_keypad(st[5]), .run_source_keypad(st[6]), .torque_over_level(st[7]), .brake_overheat(st[8]),
        .major_fault(st[9]), .minor_fault(st[10]), .reset_command(st[11]), .timer_output(st[12]),
        .reverse_run(st[13]), .restart_active(st[14]), .heatsink_prealarm(st[15]), .drive_enable(st[16]),
        .run_delay_wait(st[17]), .fan_failure(st[18]), .reference_loss_enable(loss_en), .output_speed(spd),
        .speed_command(cmd), .analog_reference(ref_v), .minimum_frequency_setting(16'h0032),
        .speed_detection_level(16'h0064), .speed_agreement_bandwidth(16'h000A), .first_contact_output(c1),
        .second_contact_output(c2), .reference_lost(lost));
    dsos_relay_load u_dsos_relay_load (.clk(clk), .rst_n(rst_n), .contact(c1), .closures_r(clo));
    task automatic cmp(input string nm, input logic exp, input logic got);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] %s expected %b seen %b", nm, exp, got);
        end
    endtask
    task automatic cmp_cnt(input string nm, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] %s expected %0d seen %0d", nm, exp, got);
        end
    endtask
    task automatic step(input logic [18:0] v, input dsos_code_t a, input dsos_code_t b, input logic e1, input logic e2);
        st = v;
        s1 = a;
        s2 = b;
        repeat (2) @(negedge clk);
        cmp("first_contact_output", e1, c1);
        cmp("second_contact_output", e2, c2);
    endtask
    task automatic sp(input logic [15:0] v, input logic [15:0] c, input dsos_code_t a, input dsos_code_t b,
                      input logic e1, input logic e2);
        spd = v;
        cmd = c;
        step(19'h0_0000, a, b, e1, e2);
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
        forever #5 clk = ~clk;
    initial
    begin
        #500us error_cnt++;
        final_report();
    end
    initial
    begin
        repeat (10) @(negedge clk);
        rst_n = 1;
        step(19'h0_0000, 8'h00, 8'h08, 0, 1);
        step(19'h0_0001, 8'h00, 8'h08, 1, 1);
        step(19'h0_0002, 8'h00, 8'h08, 1, 0);
        step(19'h0_0000, 8'h06, 8'h17, 1, 1);
        step(19'h0_0004, 8'h06, 8'h17, 0, 1);
        step(19'h0_0008, 8'h17, 8'h06, 1, 0);
        step(19'h0_2000, 8'h17, 8'h06, 0, 1);
        $display("status codes done");
        foreach (codes[i])
        begin
            step(19'h0_0001 << bits[i], codes[i], 8'h0F, 1, 0);
            step(19'h0_0000, codes[i], 8'h13, 0, 0);
        end
        $display("single input codes done");
        sp(16'h0031, 16'h0000, 8'h01, 8'h3E, 1, 0);
        sp(16'h0032, 16'h0000, 8'h01, 8'hFF, 0, 0);
        sp(16'h0064, 16'h006E, 8'h02, 8'h03, 1, 1);
        sp(16'h0064, 16'h006F, 8'h02, 8'h03, 0, 0);
        sp(16'h0059, 16'h0059, 8'h02, 8'h03, 1, 0);
        sp(16'h006F, 16'h0000, 8'h04, 8'h05, 0, 1);
        sp(16'h0069, 16'h0000, 8'h04, 8'h05, 0, 1);
        sp(16'h0064, 16'h0000, 8'h04, 8'h05, 1, 1);
        sp(16'h005F, 16'h0000, 8'h04, 8'h05, 1, 1);
        sp(16'h0059, 16'h0000, 8'h04, 8'h05, 1, 0);
        sp(16'h005F, 16'h0000, 8'h04, 8'h05, 1, 0);
        $display("speed codes done");
        loss_en = 1;
        ref_v = 16'h03E8;
        repeat (45) @(negedge clk);
        ref_v = 16'h0064;
        for (int n = 0; n < 50 && lost !== 1'b1; n++)
            @(negedge clk);
        cmp("reference_lost", 1'b1, lost);
        if (lost !== 1'b1)
            final_report();
        step(19'h0_0000, 8'h0C, 8'h0C, 1, 1);
        loss_en = 0;
        step(19'h0_0000, 8'h0C, 8'h0C, 0, 0);
        $display("reference loss done");
        rst_n = 0;
        step(19'h0_0001, 8'h00, 8'h08, 0, 0);
        cmp_cnt("closures_r", 16'h0000, clo);
        rst_n = 1;
        step(19'h0_0001, 8'h00, 8'h08, 1, 1);
        cmp_cnt("closures_r", 16'h0001, clo);
        $display("reset done");
        final_report();
    end
endmodule
